// [hw/lpw_top.v]
// Local design decisions: register access over AHB-Lite and the address map.
`timescale 1ns/1ps
`include "lpw_defs.vh"

module lpw_top (
   // clock and reset
   input  wire        MCLK,
   input  wire        RESETN,
   // ahb-lite slave
   input  wire        HSEL,
   input  wire [31:0] HADDR,
   input  wire [1:0]  HTRANS,
   input  wire        HWRITE,
   input  wire [2:0]  HSIZE,
   input  wire [31:0] HWDATA,
   input  wire        HREADY,
   output reg  [31:0] HRDATA,
   output reg         HREADYOUT,
   output reg         HRESP,
   // host pins, wake inputs idle high, link drop idle low
   input  wire        DEEP_SLEEP_WAKE_INPUT_N,
   input  wire        HOST_TX_WAKE_REQUEST_N,
   input  wire        LINK_DROP,
   // power and state outputs
   output reg         CPU_RUN,
   output reg         RADIO_ON,
   output reg         REDUCED_CURRENT,
   output reg         SYS_RESTART,
   output reg  [1:0]  OP_STATE
);

   // ------------------------------------------------------------
   // registers and wires
   // ------------------------------------------------------------
   reg  [7:0]  ctrl;          // configuration and runtime bits
   reg  [31:0] stby_to;       // standby timeout, cycles
   reg  [31:0] disc_to;       // disconnect standby timeout
   reg  [1:0]  state;         // operating state
   reg  [1:0]  next_state;
   reg  [7:0]  restart_cnt;   // restart pulse length left
   reg  [1:0]  wake_src;      // last wake source
   reg  [1:0]  next_wake_src;
   reg         had_link;      // a link has existed then dropped
   reg         wr_pend;       // write data phase pending
   reg  [5:0]  wr_addr;       // latched write offset
   reg         cmd_shut;      // shutdown opcode seen, one cycle
   reg         next_rc;       // next reduced current level
   reg  [31:0] next_rdata;

   wire        wake_pin_s;    // synced wake input, low = wake
   wire        rxind_s;       // synced request, low = wake
   wire        ldrop_s;       // synced link-drop input
   wire        stby_exp;      // standby timeout reached
   wire        disc_exp;      // disconnect timeout reached
   wire        addr_ph;       // valid address phase
   wire        restarting;    // restart pulse active
   wire        wake_trig;     // any enabled wake request

   wire auto_op  = ctrl[`LPW_B_AUTO];
   wire rxind_en = ctrl[`LPW_B_RXIND_EN];
   wire wake_en  = ctrl[`LPW_B_WAKE_EN];
   wire ldrop_en = ctrl[`LPW_B_LDROP_EN];
   wire stby_en  = ctrl[`LPW_B_STBY_EN];
   wire disc_en  = ctrl[`LPW_B_DISC_EN];
   wire linked   = ctrl[`LPW_B_LINKED];
   wire sleep_ok = ctrl[`LPW_B_SLEEP_OK];

   // ------------------------------------------------------------
   // helper functions
   // ------------------------------------------------------------
   // enable bit as the one-byte function code
   function [7:0] func_code;
      input en;
      begin
         func_code = en ? `LPW_FUNC_ON : `LPW_FUNC_OFF;
      end
   endfunction

   // wake asks only when enabled and pin low
   function wake_req;
      input en;
      input pin_n;
      begin
         wake_req = en & ~pin_n;
      end
   endfunction

   // ------------------------------------------------------------
   // input synchronisers
   // ------------------------------------------------------------
   // sync wake inputs
   lpw_sync #(.RST_VAL(1'b1)) u_sync_wake (
      .clk   (MCLK),
      .rst_n (RESETN),
      .d     (DEEP_SLEEP_WAKE_INPUT_N),
      .q     (wake_pin_s)
   );

   lpw_sync #(.RST_VAL(1'b1)) u_sync_rxind (
      .clk   (MCLK),
      .rst_n (RESETN),
      .d     (HOST_TX_WAKE_REQUEST_N),
      .q     (rxind_s)
   );

   // link-drop is sampled the same way
   lpw_sync #(.RST_VAL(1'b0)) u_sync_ldrop (
      .clk   (MCLK),
      .rst_n (RESETN),
      .d     (LINK_DROP),
      .q     (ldrop_s)
   );

   // ------------------------------------------------------------
   // timeout counters
   // ------------------------------------------------------------
   // standby timeout runs in standby
   lpw_timer u_stby_timer (
      .clk     (MCLK),
      .rst_n   (RESETN),
      .run     (auto_op & stby_en & ~restarting &
                (state == `LPW_ST_STANDBY)),
      .limit   (stby_to),
      .expired (stby_exp)
   );

   // disconnect timeout after a link drop
   lpw_timer u_disc_timer (
      .clk     (MCLK),
      .rst_n   (RESETN),
      .run     (auto_op & disc_en & had_link & ~restarting &
                (state == `LPW_ST_STANDBY)),
      .limit   (disc_to),
      .expired (disc_exp)
   );

   // ------------------------------------------------------------
   // wake and state decisions
   // ------------------------------------------------------------
   assign restarting = (restart_cnt != 8'h00);

   // wake pin gated by its enable
   // request input wakes too when enabled
   // neither enabled leaves no way out
   assign wake_trig = wake_req(wake_en, wake_pin_s) |
                      wake_req(rxind_en, rxind_s);

   // next operating state
   always @* begin
      next_state    = state;
      next_wake_src = wake_src;
      case (state)
         `LPW_ST_SHUTDOWN: begin
            if (wake_trig) begin
               next_state = auto_op ? `LPW_ST_STANDBY
                                    : `LPW_ST_IDLE;
               next_wake_src = wake_req(wake_en, wake_pin_s)
                               ? `LPW_WSRC_PIN : `LPW_WSRC_RXIND;
            end
         end
         default: begin
            if (restarting) begin
               // held in place during the restart pulse
               next_state = state;
            end else if (auto_op) begin
               if (stby_exp | disc_exp | (ldrop_en & ldrop_s))
                  next_state = `LPW_ST_SHUTDOWN;
               else if (linked)
                  next_state = `LPW_ST_LINK;
               else
                  next_state = `LPW_ST_STANDBY;
            end else begin
               if (cmd_shut)
                  next_state = `LPW_ST_SHUTDOWN;
               else if (linked)
                  next_state = `LPW_ST_LINK;
               else
                  next_state = `LPW_ST_IDLE;
            end
         end
      endcase
   end

   // doze only with request function on
   // never in shutdown, host low wakes
   always @* begin
      next_rc = rxind_en & sleep_ok & rxind_s & ~restarting &
                (next_state != `LPW_ST_SHUTDOWN);
   end

   // state, restart pulse and link history
   always @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         state       <= `LPW_ST_IDLE;
         wake_src    <= `LPW_WSRC_NONE;
         restart_cnt <= 8'h00;
         had_link    <= 1'b0;
      end else begin
         state    <= next_state;
         wake_src <= next_wake_src;
         if (state == `LPW_ST_SHUTDOWN &&
             next_state != `LPW_ST_SHUTDOWN)
            restart_cnt <= `LPW_RESTART_CYC;
         else if (restarting)
            restart_cnt <= restart_cnt - 8'h01;
         if (state == `LPW_ST_SHUTDOWN)
            had_link <= 1'b0;
         else if (state == `LPW_ST_LINK && !linked)
            had_link <= 1'b1;
         else if (linked)
            had_link <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // power outputs
   // ------------------------------------------------------------
   // shutdown stops controller and radio
   always @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         CPU_RUN         <= 1'b1;
         RADIO_ON        <= 1'b1;
         REDUCED_CURRENT <= 1'b0;
         SYS_RESTART     <= 1'b0;
         OP_STATE        <= `LPW_ST_IDLE;
      end else begin
         CPU_RUN  <= (next_state != `LPW_ST_SHUTDOWN) & ~next_rc;
         RADIO_ON <= (next_state != `LPW_ST_SHUTDOWN);
         REDUCED_CURRENT <= next_rc;
         SYS_RESTART     <= restarting |
                            ((state == `LPW_ST_SHUTDOWN) &&
                             (next_state != `LPW_ST_SHUTDOWN));
         OP_STATE <= next_state;
      end
   end

   // ------------------------------------------------------------
   // ahb-lite slave
   // ------------------------------------------------------------
   assign addr_ph = HSEL & HREADY & HTRANS[1];

   // read data chosen in the address phase
   always @* begin
      next_rdata = 32'h00000000;
      case (HADDR[`LPW_ADDR_W-1:0])
         `LPW_OFS_CTRL:    next_rdata = {24'h000000, ctrl};
         `LPW_OFS_CMD:     next_rdata = {24'h000000,
                                         func_code(rxind_en)};
         `LPW_OFS_STBY_TO: next_rdata = stby_to;
         `LPW_OFS_DISC_TO: next_rdata = disc_to;
         `LPW_OFS_STATUS:  next_rdata = {22'h000000,
                                         wake_src,
                                         restarting,
                                         REDUCED_CURRENT,
                                         RADIO_ON,
                                         CPU_RUN,
                                         2'h0,
                                         state};
         default:          next_rdata = 32'h00000000;
      endcase
      if (HADDR[31:`LPW_ADDR_W] != 26'h0000000)
         next_rdata = 32'h00000000;
   end

   // address latch, read data, zero-wait answers
   always @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         wr_pend   <= 1'b0;
         wr_addr   <= 6'h00;
         HRDATA    <= 32'h00000000;
         HREADYOUT <= 1'b1;
         HRESP     <= 1'b0;
      end else begin
         HREADYOUT <= 1'b1;
         HRESP     <= 1'b0;
         wr_pend   <= addr_ph & HWRITE &
                      (HADDR[31:`LPW_ADDR_W] == 26'h0000000);
         if (addr_ph) begin
            wr_addr <= HADDR[`LPW_ADDR_W-1:0];
            if (!HWRITE)
               HRDATA <= next_rdata;
         end
      end
   end

   // register writes in the data phase
   always @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         ctrl     <= `LPW_CTRL_RST;
         stby_to  <= `LPW_STBY_TO_RST;
         disc_to  <= `LPW_DISC_TO_RST;
         cmd_shut <= 1'b0;
      end else begin
         cmd_shut <= 1'b0;
         if (wr_pend) begin
            case (wr_addr)
               `LPW_OFS_CTRL:    ctrl    <= HWDATA[7:0];
               `LPW_OFS_STBY_TO: stby_to <= HWDATA;
               `LPW_OFS_DISC_TO: disc_to <= HWDATA;
               `LPW_OFS_CMD: begin
                  cmd_shut <= (HWDATA[7:0] == `LPW_CMD_SHUTDOWN) &
                              ~auto_op;
               end
               default: cmd_shut <= 1'b0;
            endcase
         end
         // runtime bits back to reset values
         if (state == `LPW_ST_SHUTDOWN && wake_trig)
            ctrl <= ctrl & `LPW_CTRL_RT_MASK;
      end
   end

endmodule

// [hw/lpw_defs.vh]
`ifndef LPW_DEFS_VH
`define LPW_DEFS_VH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define LPW_OFS_CTRL      6'h00
`define LPW_OFS_CMD       6'h04
`define LPW_OFS_STBY_TO   6'h08
`define LPW_OFS_DISC_TO   6'h0C
`define LPW_OFS_STATUS    6'h10
`define LPW_ADDR_W        6

// ------------------------------------------------------------
// control register fields
// ------------------------------------------------------------
`define LPW_CTRL_W        8
`define LPW_CTRL_RST      8'h00
`define LPW_B_AUTO        0
`define LPW_B_RXIND_EN    1
`define LPW_B_WAKE_EN     2
`define LPW_B_LDROP_EN    3
`define LPW_B_STBY_EN     4
`define LPW_B_DISC_EN     5
`define LPW_B_LINKED      6
`define LPW_B_SLEEP_OK    7
// runtime bits cleared when leaving shutdown
`define LPW_CTRL_RT_MASK  8'h3F

// ------------------------------------------------------------
// commands and enable codes
// ------------------------------------------------------------
`define LPW_CMD_SHUTDOWN  8'h05
`define LPW_FUNC_OFF      8'h00
`define LPW_FUNC_ON       8'h01

// ------------------------------------------------------------
// operating states
// ------------------------------------------------------------
`define LPW_ST_IDLE       2'h0
`define LPW_ST_STANDBY    2'h1
`define LPW_ST_LINK       2'h2
`define LPW_ST_SHUTDOWN   2'h3

// ------------------------------------------------------------
// wake sources and timing
// ------------------------------------------------------------
`define LPW_WSRC_NONE     2'h0
`define LPW_WSRC_PIN      2'h1
`define LPW_WSRC_RXIND    2'h2
`define LPW_RESTART_CYC   8'h10
`define LPW_STBY_TO_RST   32'h00000000
`define LPW_DISC_TO_RST   32'h00000000

`endif

// [hw/lpw_sync.v]
`timescale 1ns/1ps

// ------------------------------------------------------------
// two-flop level synchroniser
// ------------------------------------------------------------
module lpw_sync #(
   parameter RST_VAL = 1'b1
) (
   // clock and reset
   input  wire clk,
   input  wire rst_n,
   // level in and out
   input  wire d,
   output reg  q
);

   reg meta;   // first stage, read only by q

   // two stages, idle value under reset
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta <= RST_VAL;
         q    <= RST_VAL;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end

endmodule

// [hw/lpw_timer.v]
`timescale 1ns/1ps

// ------------------------------------------------------------
// timeout counter, flags when limit reached
// ------------------------------------------------------------
module lpw_timer (
   // clock and reset
   input  wire        clk,
   input  wire        rst_n,
   // control
   input  wire        run,
   input  wire [31:0] limit,
   // result
   output reg         expired
);

   reg [31:0] count;   // cycles spent running

   // count while run, restart whenever run drops
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count   <= 32'h00000000;
         expired <= 1'b0;
      end else if (!run) begin
         count   <= 32'h00000000;
         expired <= 1'b0;
      end else begin
         // a zero limit never expires
         if (limit != 32'h00000000 && count >= limit - 32'h00000001)
            expired <= 1'b1;
         else
            count <= count + 32'h00000001;
      end
   end

endmodule

// [sim/lpw_host.sv]
`timescale 1ns/1ps

// ------------------------------------------------------------
// host controller model driving the wake pins
// ------------------------------------------------------------
module lpw_host #(
   parameter WAIT_CYC = 4  // scaled uart wait after request
) (
   input  wire clk,
   output reg  wake_n,     // wake pin, pulled up when idle
   output reg  req_n,      // receive request, pulled up
   output reg  ldrop       // link drop, low when idle
);
   initial begin
      wake_n = 1'b1;
      req_n  = 1'b1;
      ldrop  = 1'b0;
   end

   task set_wake(input bit low);
      @(posedge clk);
      wake_n <= !low;
   endtask

   // request low, then wait before uart data
   task set_req(input bit low);
      @(posedge clk);
      req_n <= !low;
      if (low) repeat (WAIT_CYC) @(posedge clk);
   endtask

   // link drop level
   task set_ldrop(input bit hi);
      @(posedge clk);
      ldrop <= hi;
   endtask
endmodule

// [sim/lpw_top_properties.sv]
`timescale 1ns/1ps

// ------------------------------------------------------------
// power state checker
// ------------------------------------------------------------
module lpw_props (
   input logic       MCLK,
   input logic       RESETN,
   input logic       DEEP_SLEEP_WAKE_INPUT_N,
   input logic       HOST_TX_WAKE_REQUEST_N,
   input logic       HREADYOUT,
   input logic       HRESP,
   input logic       CPU_RUN,
   input logic       RADIO_ON,
   input logic       REDUCED_CURRENT,
   input logic       SYS_RESTART,
   input logic [1:0] OP_STATE
);
   logic [4:0] hi_cnt;  // length of restart pulse so far

   default clocking @(posedge MCLK); endclocking
   default disable iff (!RESETN);

   // counts consecutive restart cycles
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) hi_cnt <= 5'h00;
      else hi_cnt <= SYS_RESTART ? hi_cnt + 5'h01 : 5'h00;
   end

   a_shut_all_off: assert property (
      OP_STATE == 2'h3 && !SYS_RESTART |-> !CPU_RUN && !RADIO_ON)
      else $error("shutdown with controller or radio on");
   a_reduced_radio: assert property (
      REDUCED_CURRENT |-> RADIO_ON && !CPU_RUN && OP_STATE != 2'h3)
      else $error("reduced current state wrong");
   a_request_wakes: assert property (
      !HOST_TX_WAKE_REQUEST_N [*3] |-> ##1 !REDUCED_CURRENT)
      else $error("request did not end reduced current");
   a_wake_cause: assert property (
      $rose(SYS_RESTART) |-> !$past(DEEP_SLEEP_WAKE_INPUT_N, 3) ||
                             !$past(HOST_TX_WAKE_REQUEST_N, 3))
      else $error("restart without wake pin low");
   a_restart_len: assert property (
      $fell(SYS_RESTART) |-> hi_cnt == 5'h11)
      else $error("restart pulse length wrong");
   a_restart_frozen: assert property (
      SYS_RESTART && $past(SYS_RESTART) |-> $stable(OP_STATE))
      else $error("state moved during restart");
   a_wake_dest: assert property (
      $rose(SYS_RESTART) |-> OP_STATE <= 2'h1 && RADIO_ON && CPU_RUN)
      else $error("wake went to wrong state");
   a_shut_stays: assert property (
      (DEEP_SLEEP_WAKE_INPUT_N && HOST_TX_WAKE_REQUEST_N) [*3] ##0
      OP_STATE == 2'h3 |=> OP_STATE == 2'h3)
      else $error("left shutdown without wake");
   a_bus_okay: assert property (HREADYOUT && !HRESP)
      else $error("bus response not okay");
endmodule

bind lpw_top lpw_props u_props (
   .MCLK(MCLK), .RESETN(RESETN),
   .DEEP_SLEEP_WAKE_INPUT_N(DEEP_SLEEP_WAKE_INPUT_N),
   .HOST_TX_WAKE_REQUEST_N(HOST_TX_WAKE_REQUEST_N),
   .HREADYOUT(HREADYOUT), .HRESP(HRESP), .CPU_RUN(CPU_RUN),
   .RADIO_ON(RADIO_ON), .REDUCED_CURRENT(REDUCED_CURRENT),
   .SYS_RESTART(SYS_RESTART), .OP_STATE(OP_STATE)
);

// [sim/testbench.sv]
`timescale 1ns/1ps
`include "lpw_defs.vh"

module testbench;
   // ---------------------------------------------------------
   // signals
   // ---------------------------------------------------------
   logic        mclk = 1'b0, resetn = 1'b0;
   logic        hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic [1:0]  htrans = 2'h0, op_state;
   logic [2:0]  hsize = 3'h0;
   wire         hready, hresp, wake_n, req_n, ldrop;
   wire         cpu_run, radio_on, reduced, restart;
   int          err_count = 0, num_checks = 0;

   always #4 mclk = ~mclk;

   // ---------------------------------------------------------
   // design and host model
   // ---------------------------------------------------------
   lpw_top u_dut (.MCLK(mclk), .RESETN(resetn), .HSEL(hsel),
      .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
      .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready),
      .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp),
      .DEEP_SLEEP_WAKE_INPUT_N(wake_n),
      .HOST_TX_WAKE_REQUEST_N(req_n), .LINK_DROP(ldrop),
      .CPU_RUN(cpu_run), .RADIO_ON(radio_on),
      .REDUCED_CURRENT(reduced), .SYS_RESTART(restart),
      .OP_STATE(op_state));
   lpw_host u_host (.clk(mclk), .wake_n(wake_n), .req_n(req_n),
      .ldrop(ldrop));

   // ---------------------------------------------------------
   // tasks
   // ---------------------------------------------------------
   // one ahb single transfer, waits on hready
   task bus(input bit w, input [31:0] a, input [31:0] d);
      @(posedge mclk);
      hsel <= 1'b1; htrans <= 2'h2; haddr <= a; hwrite <= w;
      hsize <= 3'h2;
      do @(posedge mclk); while (hready !== 1'b1);
      hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
      do @(posedge mclk); while (hready !== 1'b1);
      rd = hrdata;
   endtask
   task chk(input [31:0] g, input [31:0] e);
      num_checks++;
      if (g !== e) begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // bounded poll: k=0 state s, k=1 restart high
   task poll(input int k, input [1:0] s);
      int i;
      i = 0;
      while (i < 400 && !(k == 0 ? op_state === s : restart === 1'b1))
      begin
         @(posedge mclk); #1; i++;
      end
   endtask
   task do_reset;
      @(posedge mclk); resetn <= 1'b0;
      repeat (20) @(posedge mclk);
      resetn <= 1'b1;
   endtask
   task complete_run;
      $display("checks=%0d mismatches=%0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   // ---------------------------------------------------------
   // watchdog
   // ---------------------------------------------------------
   initial begin
      repeat (20000) @(posedge mclk);
      err_count++;
      complete_run;
   end

   // ---------------------------------------------------------
   // tests
   // ---------------------------------------------------------
   initial begin
      do_reset;
      bus(0, `LPW_OFS_CTRL, 0); chk(rd, 32'h0);
      bus(0, 32'h40, 0); chk(rd, 32'h0);
      #1 chk(op_state, `LPW_ST_IDLE); chk(cpu_run, 1'b1);
      $display("test reset done");
      // sleep hint without request function
      bus(1, `LPW_OFS_CTRL, 32'h80);
      repeat (10) @(posedge mclk); #1 chk(reduced, 1'b0);
      bus(1, `LPW_OFS_CTRL, 32'h82);
      repeat (10) @(posedge mclk); #1 chk(reduced, 1'b1);
      chk({cpu_run, radio_on}, 2'h1);
      u_host.set_req(1); #1 chk({reduced, cpu_run}, 2'h1);
      $display("test reduced current done");
      // enable wake functions before shutdown
      // request released first so it cannot wake shutdown at once
      u_host.set_req(0); repeat (4) @(posedge mclk);
      bus(1, `LPW_OFS_CTRL, 32'h46);
      bus(1, `LPW_OFS_CMD, `LPW_CMD_SHUTDOWN);
      poll(0, `LPW_ST_SHUTDOWN); chk(op_state, 2'h3);
      chk({cpu_run, radio_on}, 2'h0);
      u_host.set_wake(1); poll(1, 0); chk(restart, 1'b1);
      chk(op_state, `LPW_ST_IDLE);
      u_host.set_wake(0); repeat (30) @(posedge mclk);
      bus(0, `LPW_OFS_CTRL, 0); chk(rd, 32'h06);
      bus(0, `LPW_OFS_STATUS, 0); chk(rd, 32'h00000130);
      $display("test manual wake done");
      bus(1, `LPW_OFS_CTRL, 32'h00);
      bus(1, `LPW_OFS_CMD, `LPW_CMD_SHUTDOWN);
      poll(0, `LPW_ST_SHUTDOWN);
      u_host.set_wake(1); u_host.set_req(1);
      repeat (20) @(posedge mclk); #1 chk(op_state, 2'h3);
      u_host.set_wake(0); u_host.set_req(0); do_reset;
      @(posedge mclk); #1 chk(op_state, `LPW_ST_IDLE);
      $display("test no wake source done");
      bus(1, `LPW_OFS_CTRL, 32'h09);
      u_host.set_ldrop(1); poll(0, `LPW_ST_SHUTDOWN);
      chk(op_state, 2'h3);
      u_host.set_ldrop(0); do_reset;
      $display("test link drop done");
      bus(1, `LPW_OFS_STBY_TO, 32'h0000000A);
      bus(1, `LPW_OFS_CTRL, 32'h13);
      poll(0, `LPW_ST_SHUTDOWN); chk(op_state, 2'h3);
      u_host.set_req(1); poll(1, 0); chk(restart, 1'b1);
      chk(op_state, `LPW_ST_STANDBY);
      u_host.set_req(0); do_reset;
      $display("test auto timeout done");
      complete_run;
   end
endmodule
